// ==== hw/smc_pkg.sv ====
// Package of constants and types for the sleep-mode controller
package smc_pkg;

  // ********************************************************************
  // Mode select encodings
  // ********************************************************************
  localparam logic [2:0] SMC_MODE_IDLE     = 3'h0;
  localparam logic [2:0] SMC_MODE_NOISE    = 3'h1;
  localparam logic [2:0] SMC_MODE_PDOWN    = 3'h2;
  localparam logic [2:0] SMC_MODE_PSAVE    = 3'h3;
  localparam logic [2:0] SMC_MODE_STANDBY  = 3'h6;
  localparam logic [2:0] SMC_MODE_EXTSTBY  = 3'h7;

  // ********************************************************************
  // Timing constants
  // ********************************************************************
  localparam int          SMC_HALT_EXTRA_CYC   = 4;   // Core held after start-up
  localparam int          SMC_STANDBY_WAKE_CYC = 6;   // Oscillator kept running
  localparam logic [15:0] SMC_STARTUP_DEF      = 16'h0400;
  localparam int          SMC_CNT_W            = 16;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [2:0] SMC_MODE_RST = 3'h0;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    SMC_ST_RUN    = 3'b000,
    SMC_ST_SLEEP  = 3'b001,
    SMC_ST_START  = 3'b010,
    SMC_ST_HALT   = 3'b011,
    SMC_ST_RESUME = 3'b100
  } smc_state_type;

  // Clock domain and oscillator gates
  typedef struct packed {
    logic core_clock;
    logic program_mem_clock;
    logic periph_io_clock;
    logic converter_clock;
    logic async_clock;
    logic main_osc;
    logic timer_osc;
  } smc_clk_type;

  // Wake sources seen from the peripherals
  typedef struct packed {
    logic any_irq;            // Any enabled interrupt (Idle)
    logic ext_level;          // Level interrupt on ext_irq_pin_a/b
    logic ext_edge;           // Edge interrupt on ext_irq_pin_a/b
    logic pin_change_irq;
    logic two_wire_match;
    logic timer2_irq;
    logic self_program_rdy;   // self_program_op / nonvolatile ready
    logic conv_done;
    logic watchdog_irq;
  } smc_wake_type;

  // Timer 2 configuration
  typedef struct packed {
    logic enabled;
    logic async_mode;
    logic sync_clocked;
    logic irq_enabled;        // From timer2_irq_mask
  } smc_t2_type;

endpackage : smc_pkg

// ==== hw/smc_wake_filter.sv ====
// Wake-source qualifier: picks the sources allowed in the selected mode
module smc_wake_filter
  import smc_pkg::*;
(
  input  wire logic [2:0]   i_mode,
  input  wire smc_wake_type i_wake,
  input  wire smc_t2_type   i_t2,
  input  wire logic         i_global_irq_en,
  output logic              o_wake
);

  logic t2_ok;
  logic common;

  // ********************************************************************
  // Mode qualification
  // ********************************************************************
  always_comb begin
    t2_ok  = i_t2.enabled && i_t2.irq_enabled && i_global_irq_en && i_wake.timer2_irq;
    common = i_wake.ext_level || i_wake.pin_change_irq || i_wake.two_wire_match || i_wake.watchdog_irq;
    case (i_mode)
      SMC_MODE_IDLE:   o_wake = i_wake.any_irq || i_wake.ext_edge || common || i_wake.conv_done
                                || i_wake.self_program_rdy || (t2_ok && i_t2.async_mode);
      SMC_MODE_NOISE:  o_wake = common || i_wake.conv_done || i_wake.self_program_rdy
                                || (t2_ok && i_t2.async_mode);
      SMC_MODE_PDOWN,
      SMC_MODE_STANDBY: o_wake = common;
      SMC_MODE_PSAVE:  o_wake = common || t2_ok;
      SMC_MODE_EXTSTBY: o_wake = common || (t2_ok && i_t2.async_mode);
      default:         o_wake = 1'b0;
    endcase
  end

endmodule // smc_wake_filter

// ==== hw/smc_clock_gates.sv ====
// Clock-domain and oscillator gate table per sleep mode
module smc_clock_gates
  import smc_pkg::*;
(
  input  wire logic       i_asleep,
  input  wire logic [2:0] i_mode,
  input  wire smc_t2_type i_t2,
  input  wire logic       i_conv_enabled,
  output smc_clk_type     o_gate
);

  // ********************************************************************
  // Gate table
  // ********************************************************************
  always_comb begin
    o_gate = '{default: 1'b1};
    if (i_asleep) begin
      o_gate = '{default: 1'b0};
      case (i_mode)
        SMC_MODE_IDLE: begin
          o_gate.periph_io_clock = 1'b1;
          o_gate.converter_clock = 1'b1;
          o_gate.main_osc        = 1'b1;
          o_gate.async_clock     = i_t2.async_mode;
          o_gate.timer_osc       = i_t2.async_mode;
        end
        SMC_MODE_NOISE: begin
          o_gate.converter_clock = i_conv_enabled;
          o_gate.main_osc        = 1'b1;
          o_gate.async_clock     = i_t2.async_mode;
          o_gate.timer_osc       = i_t2.async_mode;
        end
        SMC_MODE_PSAVE: begin
          o_gate.async_clock = i_t2.enabled && i_t2.async_mode;
          o_gate.timer_osc   = i_t2.enabled && i_t2.async_mode;
          o_gate.main_osc    = i_t2.enabled && i_t2.sync_clocked;
        end
        SMC_MODE_STANDBY: o_gate.main_osc = 1'b1;
        SMC_MODE_EXTSTBY: begin
          o_gate.main_osc    = 1'b1;
          o_gate.async_clock = i_t2.async_mode;
          o_gate.timer_osc   = i_t2.async_mode;
        end
        default: o_gate = '{default: 1'b0};
      endcase
    end
  end

endmodule // smc_clock_gates

// ==== hw/smc_sleep_ctrl.sv ====
// Sleep-mode controller top: sequencing, wake delays and gate outputs
module smc_sleep_ctrl
  import smc_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  input  wire logic         i_sleep_arm_bit,
  input  wire logic [2:0]   i_sleep_mode_select,
  input  wire logic         i_sleep_instr,
  input  wire logic         i_ext_crystal,
  input  wire logic [15:0]  i_startup_cycles,
  input  wire logic         i_conv_enabled,
  input  wire logic         i_global_irq_en,
  input  wire smc_wake_type i_wake,
  input  wire smc_t2_type   i_t2,
  input  wire logic         i_sys_reset_req,
  output logic              o_asleep,
  output logic              o_core_halt,
  output logic              o_take_irq,
  output logic              o_reset_vector,
  output logic              o_conv_start,
  output smc_clk_type       o_clk_gate,
  output logic [2:0]        o_active_mode
);

  // ********************************************************************
  // State
  // ********************************************************************
  smc_state_type          state;
  smc_state_type          next_state;
  logic [SMC_CNT_W-1:0]   count;
  logic [SMC_CNT_W-1:0]   next_count;
  logic [2:0]             mode;
  logic [2:0]             next_mode;
  logic                   woke_by_reset;
  logic                   next_woke_by_reset;
  logic                   take_irq;
  logic                   next_take_irq;
  logic                   conv_start;
  logic                   next_conv_start;
  logic                   reset_vector;
  logic                   next_reset_vector;
  logic                   wake;
  logic                   mode_legal;
  logic [SMC_CNT_W-1:0]   start_len;
  smc_clk_type            gate_c;
  smc_clk_type            clk_gate;
  smc_clk_type            next_clk_gate;
  logic                   asleep;
  logic                   next_asleep;
  logic                   core_halt;
  logic                   next_core_halt;
  logic                   sleep_take;
  logic                   resume_to_vector;
  logic                   count_done;

  smc_wake_filter u_wake (
    .i_mode          (mode),
    .i_wake          (i_wake),
    .i_t2            (i_t2),
    .i_global_irq_en (i_global_irq_en),
    .o_wake          (wake)
  );

  smc_clock_gates u_gates (
    .i_asleep       (asleep),
    .i_mode         (mode),
    .i_t2           (i_t2),
    .i_conv_enabled (i_conv_enabled),
    .o_gate         (gate_c)
  );

  // ********************************************************************
  // Mode decode
  // ********************************************************************
  always_comb begin
    case (i_sleep_mode_select)
      SMC_MODE_IDLE, SMC_MODE_NOISE,
      SMC_MODE_PDOWN, SMC_MODE_PSAVE:     mode_legal = 1'b1;
      SMC_MODE_STANDBY, SMC_MODE_EXTSTBY: mode_legal = i_ext_crystal;
      default:                            mode_legal = 1'b0;
    endcase
    sleep_take = i_sleep_instr && i_sleep_arm_bit && mode_legal;
    // Power-down and power-save pay the full start-up, standby modes 6 cycles; idle and noise keep the oscillator
    case (mode)
      SMC_MODE_PDOWN, SMC_MODE_PSAVE: start_len = (i_startup_cycles == 16'h0000) ? 16'h0001 : i_startup_cycles;
      SMC_MODE_STANDBY, SMC_MODE_EXTSTBY: start_len = SMC_CNT_W'(SMC_STANDBY_WAKE_CYC);
      default: start_len = 16'h0001;
    endcase
  end

  // ********************************************************************
  // Sequencer next state
  // ********************************************************************
  // storage left untouched
  // Only clock gates move here; register file and data memory keep their contents
  always_comb begin
    next_state = state;
    case (state)
      SMC_ST_RUN: begin
        if (sleep_take) begin
          next_state = SMC_ST_SLEEP;
        end
      end
      SMC_ST_SLEEP: begin
        if (i_sys_reset_req || wake) begin
          next_state = SMC_ST_START;
        end
      end
      SMC_ST_START: begin
        if (count_done) begin
          next_state = SMC_ST_HALT;
        end
      end
      SMC_ST_HALT: begin
        if (count_done) begin
          next_state = SMC_ST_RESUME;
        end
      end
      SMC_ST_RESUME: next_state = SMC_ST_RUN;
      default:       next_state = SMC_ST_RUN;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state <= SMC_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ********************************************************************
  // Delay counter
  // ********************************************************************
  // One counter serves start-up and halt; it is reloaded on entry to start-up and on entry to halt
  always_comb begin
    count_done = (count <= 16'h0001);
    next_count = count;
    case (state)
      SMC_ST_SLEEP: begin
        if (i_sys_reset_req || wake) begin
          next_count = start_len;
        end
      end
      SMC_ST_START: begin
        if (count_done) begin
          next_count = SMC_CNT_W'(SMC_HALT_EXTRA_CYC);
        end else begin
          next_count = count - 16'h0001;
        end
      end
      SMC_ST_HALT: begin
        if (!count_done) begin
          next_count = count - 16'h0001;
        end
      end
      default: next_count = count;
    endcase
  end

  // Counter register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ********************************************************************
  // Latched mode and reset cause
  // ********************************************************************
  // Mode is frozen at entry, so a select change during sleep cannot alter gates or wake sources
  always_comb begin
    next_mode          = mode;
    next_woke_by_reset = woke_by_reset;
    case (state)
      SMC_ST_RUN: begin
        if (sleep_take) begin
          next_mode = i_sleep_mode_select;
        end
      end
      // A reset request is latched through start-up so a short pulse still reaches the vector
      SMC_ST_SLEEP, SMC_ST_START: begin
        if (i_sys_reset_req) begin
          next_woke_by_reset = 1'b1;
        end
      end
      SMC_ST_RESUME: next_woke_by_reset = 1'b0;
      default:       next_woke_by_reset = woke_by_reset;
    endcase
  end

  // Mode and reset-cause registers
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mode          <= SMC_MODE_RST;
      woke_by_reset <= 1'b0;
    end else begin
      mode          <= next_mode;
      woke_by_reset <= next_woke_by_reset;
    end
  end

  // ********************************************************************
  // Event pulses
  // ********************************************************************
  // A reset seen asleep, during start-up or in the resume cycle outranks the interrupt; one only during halt is lost
  always_comb begin
    resume_to_vector  = woke_by_reset || i_sys_reset_req;
    next_conv_start   = 1'b0;
    next_take_irq     = 1'b0;
    next_reset_vector = 1'b0;
    if ((state == SMC_ST_RUN) && sleep_take) begin
      next_conv_start = (i_sleep_mode_select == SMC_MODE_NOISE) && i_conv_enabled;
    end
    if (state == SMC_ST_RESUME) begin
      next_reset_vector = resume_to_vector;
      next_take_irq     = !resume_to_vector && wake;
    end
  end

  // Single-cycle pulses: the core must act on each in the one cycle it stands
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      take_irq     <= 1'b0;
      conv_start   <= 1'b0;
      reset_vector <= 1'b0;
    end else begin
      take_irq     <= next_take_irq;
      conv_start   <= next_conv_start;
      reset_vector <= next_reset_vector;
    end
  end

  // ********************************************************************
  // Status and gate registers
  // ********************************************************************
  // Asleep and halt follow the next state, so they change on the same edge as the state
  always_comb begin
    next_asleep    = (next_state == SMC_ST_SLEEP);
    next_core_halt = (next_state != SMC_ST_RUN);
    next_clk_gate  = gate_c;
  end

  // Gates lag the state by one cycle; the core is already held off by the halt flag then
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      asleep    <= 1'b0;
      core_halt <= 1'b0;
      clk_gate  <= '{default: 1'b1};
    end else begin
      asleep    <= next_asleep;
      core_halt <= next_core_halt;
      clk_gate  <= next_clk_gate;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Every output is a register copy, so the core never sees decode glitches
  always_comb begin
    o_asleep       = asleep;
    o_core_halt    = core_halt;
    o_take_irq     = take_irq;
    o_reset_vector = reset_vector;
    o_conv_start   = conv_start;
    o_clk_gate     = clk_gate;
    o_active_mode  = mode;
  end

endmodule // smc_sleep_ctrl

// ==== verification/smc_sleep_ctrl_asserts.sv ====
// Port-level checker of the sleep-mode controller
module smc_sleep_ctrl_chk
  import smc_pkg::*;
(
  input wire logic         i_clk_sys,
  input wire logic         i_reset,
  input wire logic         i_sleep_arm_bit,
  input wire logic [2:0]   i_sleep_mode_select,
  input wire logic         i_sleep_instr,
  input wire logic         i_ext_crystal,
  input wire logic         i_conv_enabled,
  input wire smc_wake_type i_wake,
  input wire logic         i_sys_reset_req,
  input wire logic         o_asleep,
  input wire logic         o_core_halt,
  input wire logic         o_conv_start,
  input wire smc_clk_type  o_clk_gate,
  input wire logic [2:0]   o_active_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Helpers
  // ********
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic was_asleep;
  logic legal;
  logic pd_wake;
  // Legal codes; 110/111 need a crystal clock
  assign legal = i_sleep_mode_select < 3'h4 || (i_sleep_mode_select > 3'h5 && i_ext_crystal);
  assign pd_wake = i_wake.ext_level || i_wake.pin_change_irq || i_wake.two_wire_match || i_wake.watchdog_irq;
  // Gates lag entry by a cycle, so judge them from the second asleep cycle
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      was_asleep <= 1'b0;
    end else begin
      was_asleep <= o_asleep;
    end
  end
  sequence halt_run_s;
    o_core_halt ##1 !o_core_halt;
  endsequence
  // ********
  // Properties
  // ********
  sleep_entry_a : assert property (
    i_sleep_instr && i_sleep_arm_bit && !o_core_halt && legal |=> o_asleep) else $error("armed sleep not taken");
  undef_mode_a : assert property (
    i_sleep_instr && !o_core_halt && i_sleep_mode_select inside {3'h4, 3'h5} |=> !o_core_halt)
    else $error("undefined mode slept");
  idle_gates_a : assert property (
    o_asleep && was_asleep && o_active_mode == SMC_MODE_IDLE |->
    !o_clk_gate.core_clock && !o_clk_gate.program_mem_clock && o_clk_gate.periph_io_clock)
    else $error("idle gates wrong");
  noise_gates_a : assert property (
    o_asleep && was_asleep && o_active_mode == SMC_MODE_NOISE |-> !o_clk_gate.periph_io_clock && o_clk_gate.main_osc)
    else $error("noise gates wrong");
  pdown_gates_a : assert property (
    o_asleep && was_asleep && o_active_mode == SMC_MODE_PDOWN |-> o_clk_gate == '0) else $error("pdown gates wrong");
  stby_osc_a : assert property (
    o_asleep && was_asleep && o_active_mode == SMC_MODE_STANDBY |-> o_clk_gate.main_osc && !o_clk_gate.periph_io_clock)
    else $error("standby osc wrong");
  conv_start_a : assert property (
    $rose(o_asleep) && o_active_mode == SMC_MODE_NOISE && $past(i_conv_enabled) |-> o_conv_start)
    else $error("no conversion start");
  idle_wake_a : assert property (
    $fell(o_asleep) && o_active_mode == SMC_MODE_IDLE && !i_sys_reset_req |-> ##5 halt_run_s)
    else $error("idle wake length wrong");
  stby_wake_a : assert property (
    $fell(o_asleep) && o_active_mode == SMC_MODE_STANDBY && !i_sys_reset_req |-> ##10 halt_run_s)
    else $error("standby wake length wrong");
  pdown_filter_a : assert property (
    o_asleep && o_active_mode == SMC_MODE_PDOWN && !i_sys_reset_req && !pd_wake |=> o_asleep)
    else $error("pdown woke on bad source");
endmodule // smc_sleep_ctrl_chk

bind smc_sleep_ctrl smc_sleep_ctrl_chk u_chk (.i_clk_sys, .i_reset, .i_sleep_arm_bit, .i_sleep_mode_select,
  .i_sleep_instr, .i_ext_crystal, .i_conv_enabled, .i_wake, .i_sys_reset_req, .o_asleep, .o_core_halt,
  .o_conv_start, .o_clk_gate, .o_active_mode);

// ==== verification/smc_core_model.sv ====
// Core model that executes the sleep instruction on request
module smc_core_model (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_go,
  input  wire logic i_core_halt,
  output logic      o_sleep_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Instruction pulse
  // ********
  // one-cycle sleep instruction
  // A halted core cannot execute, so requests during halt are dropped
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_sleep_instr <= 1'b0;
    end else begin
      o_sleep_instr <= i_go && !i_core_halt && !o_sleep_instr;
    end
  end
endmodule // smc_core_model

// ==== verification/tb.sv ====
// Self-checking bench of the sleep-mode controller
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb
  import smc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] m; logic x; logic a; logic s; smc_clk_type g; logic [7:0] n;} smc_row_type;
  logic i_clk_sys, i_reset, arm, xtal, conv, gie, srst, go, sinstr, asleep, halt, tirq, rvec, cstart;
  logic [2:0] mode, amode;
  logic [7:0] n;
  smc_wake_type wake;
  smc_t2_type t2;
  smc_clk_type gate;
  int err_total, check_count;
  // Mode, crystal, arm, asleep, gates, cycles to run (start-up count 3)
  smc_row_type rows [10] = '{'{3'h0, 1'b0, 1'b1, 1'b1, 7'h1A, 8'h07}, '{3'h1, 1'b0, 1'b1, 1'b1, 7'h0A, 8'h07},
    '{3'h2, 1'b0, 1'b1, 1'b1, 7'h00, 8'h09}, '{3'h3, 1'b0, 1'b1, 1'b1, 7'h00, 8'h09},
    '{3'h6, 1'b1, 1'b1, 1'b1, 7'h02, 8'h0C}, '{3'h7, 1'b1, 1'b1, 1'b1, 7'h02, 8'h0C},
    '{3'h4, 1'b1, 1'b1, 1'b0, 7'h7F, 8'h00}, '{3'h5, 1'b1, 1'b1, 1'b0, 7'h7F, 8'h00},
    '{3'h6, 1'b0, 1'b1, 1'b0, 7'h7F, 8'h00}, '{3'h0, 1'b0, 1'b0, 1'b0, 7'h7F, 8'h00}};
  smc_sleep_ctrl dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sleep_arm_bit(arm), .i_sleep_mode_select(mode),
    .i_sleep_instr(sinstr), .i_ext_crystal(xtal), .i_startup_cycles(16'h0003), .i_conv_enabled(conv),
    .i_global_irq_en(gie), .i_wake(wake), .i_t2(t2), .i_sys_reset_req(srst), .o_asleep(asleep),
    .o_core_halt(halt), .o_take_irq(tirq), .o_reset_vector(rvec), .o_conv_start(cstart), .o_clk_gate(gate),
    .o_active_mode(amode));
  smc_core_model u_core (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_go(go), .i_core_halt(halt),
    .o_sleep_instr(sinstr));
  // ********
  // Tasks
  // ********
  // Inputs move 1 ns after the edge so the design samples settled values
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Sleep instruction reaches the design one edge after the request
  task automatic sleep_go(input logic [2:0] m);
    mode = m;
    go = 1'b1;
    tick();
    go = 1'b0;
    tick();
  endtask
  // Bounded wait for the core to run again
  task automatic run_wake();
    n = 8'h00;
    while (halt !== 1'b0 && n < 8'd60) begin
      tick();
      n++;
    end
    if (halt !== 1'b0) begin
      err_total++;
      wrap_up();
    end
  endtask
  // Clock of 10 ns
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // ********
  // Main sequence
  // ********
  initial begin
    {arm, xtal, srst, go, mode, wake, t2} = '0;
    {conv, gie, i_reset} = 3'b111;
    repeat (2) @(posedge i_clk_sys);
    #1 i_reset = 1'b0;
    // Table of modes; the watchdog wakes every mode
    for (int i = 0; i < 10; i++) begin
      arm = rows[i].a;
      xtal = rows[i].x;
      sleep_go(rows[i].m);
      repeat (2) tick();
      `CHK("asleep", rows[i].s, asleep)
      `CHK("gates", rows[i].g, gate)
      if (rows[i].s) begin
        wake.watchdog_irq = 1'b1;
        run_wake();
        `CHK("wake_len", rows[i].n, n)
        `CHK("take_irq", 1'b1, tirq)
        `CHK("mode", rows[i].m, amode)
        wake = '0;
      end
    end
    arm = 1'b1;
    // Level dropped before start-up ends: wake without handler
    sleep_go(SMC_MODE_PDOWN);
    repeat (2) tick();
    wake.ext_level = 1'b1;
    tick();
    wake = '0;
    run_wake();
    `CHK("lost_level", 1'b0, tirq)
    // Edge trigger ignored, then reset while asleep
    sleep_go(SMC_MODE_PDOWN);
    wake.ext_edge = 1'b1;
    repeat (3) tick();
    `CHK("edge_ignored", 1'b1, asleep)
    wake = '0;
    srst = 1'b1;
    tick();
    srst = 1'b0;
    n = 8'h00;
    while (rvec !== 1'b1 && n < 8'd60) begin
      tick();
      n++;
    end
    if (rvec !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    `CHK("reset_vec", 1'b1, rvec)
    `CHK("no_irq", 1'b0, tirq)
    // Noise mode starts a conversion; conversion done wakes
    sleep_go(SMC_MODE_NOISE);
    `CHK("conv_start", 1'b1, cstart)
    wake.conv_done = 1'b1;
    run_wake();
    `CHK("conv_wake", 1'b1, tirq)
    wake = '0;
    // Asynchronous timer 2 keeps its clocks in power-save and idle
    t2 = '{1'b1, 1'b1, 1'b0, 1'b1};
    sleep_go(SMC_MODE_PSAVE);
    repeat (2) tick();
    `CHK("timer_osc", 1'b1, gate.timer_osc)
    wake.timer2_irq = 1'b1;
    run_wake();
    `CHK("t2_wake", 1'b1, tirq)
    wake = '0;
    sleep_go(SMC_MODE_IDLE);
    repeat (2) tick();
    `CHK("async_clk", 1'b1, gate.async_clock)
    wake.any_irq = 1'b1;
    run_wake();
    `CHK("idle_wake", 1'b1, tirq)
    // Asynchronous reset in mid-sleep returns the block to run with all clocks on
    sleep_go(SMC_MODE_PDOWN);
    repeat (2) tick();
    i_reset = 1'b1;
    tick();
    `CHK("rst_asleep", 1'b0, asleep)
    `CHK("rst_halt", 1'b0, halt)
    `CHK("rst_gates", 7'h7F, gate)
    i_reset = 1'b0;
    tick();
    wrap_up();
  end
endmodule // tb
